// ### sso_status_out.sv
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sso_map.svh"
module sso_status_out import sso_pkg::*; #(
    parameter int DW = 32,
    parameter logic [31:0] ALM_MIN_CYC = `SSO_ALM_MIN_CYC,
    parameter logic [31:0] ALM_MAX_CYC = `SSO_ALM_MAX_CYC
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Servo conditions, same clock
    input wire logic alarm,
    input wire logic base_shutoff,
    input wire logic amp_ready,
    input wire logic dyn_brake_req,
    input wire logic power_dip,
    input wire logic [1:0] ctrl_mode,
    input wire logic signed [DW-1:0] droop_count,
    input wire logic signed [DW-1:0] motor_speed,
    input wire logic signed [DW-1:0] cmd_speed,
    // Status pins
    output logic [2:0] out_pin,
    output logic brake_interlock,
    output logic malfunction_out,
    output logic in_position,
    output logic dyn_brake_interlock,
    output logic ready,
    output logic speed_reached,
    output logic servo_on_eff,
    output logic irq
);
    typedef struct packed {
        logic servo_on;
        logic [31:0] in_position_range_param;
        logic [31:0] brake_delay_param;
        logic [11:0] assign_param;
        logic [31:0] pwr_cnt;
        logic pwr_done;
        logic dip_latch;
        logic brk, malf, inp, dbi, rdy, sa;
        logic [2:0] pins;
        logic [5:0] irq_stat;
        logic [5:0] irq_en;
        logic irq;
        logic son;
        sso_bus_st_t bus;
        logic [31:0] rdata;
    } sso_state_t;

    sso_state_t s_reg, s_next;
    logic [2:0] mux_pins;
    logic db_assigned;
    logic servo_eff;
    logic [DW-1:0] abs_droop, abs_cmd, abs_err, win;
    logic [5:0] now_vec, prev_vec;

    // Dynamic brake interlock assigned to any pin
    assign db_assigned = (s_reg.assign_param[3:0] == SSO_SRC_DYNBRK)
        || (s_reg.assign_param[7:4] == SSO_SRC_DYNBRK)
        || (s_reg.assign_param[11:8] == SSO_SRC_DYNBRK);
    // Power dip with interlock assigned drops servo-on
    assign servo_eff = s_reg.servo_on && !s_reg.dip_latch; // R11
    assign abs_droop = droop_count[DW-1] ? DW'(-droop_count) : droop_count;
    assign abs_cmd = cmd_speed[DW-1] ? DW'(-cmd_speed) : cmd_speed;
    assign abs_err = (motor_speed >= cmd_speed) ?
        DW'(motor_speed - cmd_speed) : DW'(cmd_speed - motor_speed);
    // Tolerance window: 5 percent of command plus fixed offset
    assign win = DW'((abs_cmd * `SSO_SA_PCT_NUM) / `SSO_SA_PCT_DEN)
        + DW'(`SSO_SA_OFFSET); // R14
    assign now_vec = {s_reg.sa, s_reg.rdy, s_reg.dbi, s_reg.inp,
        s_reg.malf, s_reg.brk};
    assign prev_vec = {s_next.sa, s_next.rdy, s_next.dbi, s_next.inp,
        s_next.malf, s_next.brk};

    sso_pin_mux #(.PINS(3)) u_mux (
        .sel(s_reg.assign_param),
        .status({2'b00, s_reg.sa, s_reg.rdy, s_reg.dbi, s_reg.malf,
            s_reg.inp, s_reg.brk}),
        .pin(mux_pins)
    );

    // Next-state logic, evaluated once per control cycle
    always_comb begin
        s_next = s_reg;
        // Power-up timer: malfunction only after settle window
        if (!s_reg.pwr_done) begin
            s_next.pwr_cnt = s_reg.pwr_cnt + 32'd1;
            if (s_reg.pwr_cnt + 32'd1 >= ALM_MIN_CYC) begin
                s_next.pwr_done = 1'b1; // R5
            end
        end
        if (power_dip && db_assigned) begin
            s_next.dip_latch = 1'b1; // R11
        end
        s_next.brk = servo_eff && !alarm; // R2
        s_next.malf = s_reg.pwr_done && !alarm && !base_shutoff; // R4 R5
        s_next.inp = (ctrl_mode == SSO_MODE_POS)
            && (abs_droop <= DW'(s_reg.in_position_range_param)); // R6 R7
        s_next.dbi = !dyn_brake_req; // R9
        s_next.rdy = servo_eff && amp_ready && !alarm; // R12
        s_next.sa = servo_eff && (ctrl_mode == SSO_MODE_VEL) // R13 R16
            && ((abs_cmd <= DW'(`SSO_SA_OFFSET)) || (abs_err <= win)); // R15
        s_next.pins = mux_pins; // R1 R17
        // Rising status bits are sticky events
        s_next.irq_stat = s_reg.irq_stat | (prev_vec & ~now_vec);
        s_next.bus = SSO_BUS_IDLE;
        if (s_reg.bus == SSO_BUS_IDLE && (avs_read || avs_write)) begin
            s_next.bus = SSO_BUS_ANSWER;
            s_next.rdata = 32'h0000_0000;
            if (avs_read) begin
                case (avs_address)
                    `SSO_ADDR_CTRL: s_next.rdata = {31'h0, s_reg.servo_on};
                    `SSO_ADDR_INPR: s_next.rdata = s_reg.in_position_range_param;
                    `SSO_ADDR_ASSIGN: s_next.rdata = {20'h0, s_reg.assign_param};
                    `SSO_ADDR_STATUS: s_next.rdata = {21'h0, s_reg.dip_latch,
                        s_reg.pwr_done, s_reg.pins, now_vec};
                    `SSO_ADDR_IRQ_STAT: s_next.rdata = {26'h0, s_reg.irq_stat};
                    `SSO_ADDR_IRQ_EN: s_next.rdata = {26'h0, s_reg.irq_en};
                    `SSO_ADDR_BRK_DLY: s_next.rdata = s_reg.brake_delay_param;
                    default: s_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Writes land only at the edge where waitrequest is seen low
        if (s_reg.bus == SSO_BUS_ANSWER && avs_write) begin
            case (avs_address)
                `SSO_ADDR_CTRL: begin
                    s_next.servo_on = avs_writedata[`SSO_CTRL_SERVO_ON];
                    if (!avs_writedata[`SSO_CTRL_SERVO_ON]) begin
                        s_next.dip_latch = 1'b0;
                    end
                end
                `SSO_ADDR_INPR: s_next.in_position_range_param = avs_writedata;
                `SSO_ADDR_ASSIGN: s_next.assign_param = avs_writedata[11:0];
                `SSO_ADDR_IRQ_EN: s_next.irq_en = avs_writedata[5:0];
                // Set wins over clear
                `SSO_ADDR_IRQ_CLR: s_next.irq_stat = (s_reg.irq_stat
                    & ~avs_writedata[5:0]) | (prev_vec & ~now_vec);
                `SSO_ADDR_BRK_DLY: s_next.brake_delay_param = avs_writedata;
                default: s_next.bus = SSO_BUS_IDLE;
            endcase
        end
        s_next.son = s_next.servo_on && !s_next.dip_latch; // R11
        s_next.irq = |(s_next.irq_stat & s_next.irq_en);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.in_position_range_param <= `SSO_INPR_RESET;
            s_reg.brake_delay_param <= `SSO_BRK_DLY_RESET;
            s_reg.assign_param <= `SSO_ASSIGN_RESET; // R1
            s_reg.dbi <= 1'b0;
        end else if (clk_en) begin
            s_reg <= s_next; // R17
        end
    end

    // Outputs straight from state
    assign out_pin = s_reg.pins;
    assign brake_interlock = s_reg.brk;
    assign malfunction_out = s_reg.malf;
    assign in_position = s_reg.inp;
    assign dyn_brake_interlock = s_reg.dbi;
    assign ready = s_reg.rdy;
    assign speed_reached = s_reg.sa;
    assign servo_on_eff = s_reg.son;
    assign irq = s_reg.irq;
    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = !(s_reg.bus == SSO_BUS_ANSWER);

    // Checks
    chk_brake_alarm_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && alarm |=> !brake_interlock) // R2
        else $error("brake interlock on after alarm");
    chk_malf_shutoff: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && base_shutoff |=> !malfunction_out) // R4
        else $error("malfunction on during shutoff");
    chk_malf_early: assert property (@(posedge sys_clk) disable iff (!rst_b)
        malfunction_out |-> s_reg.pwr_cnt >= ALM_MIN_CYC - 32'd1) // R5
        else $error("malfunction on too early");
    chk_malf_late: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_reg.pwr_cnt <= ALM_MAX_CYC) // R5
        else $error("power timer exceeded maximum");
    chk_inpos_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && ctrl_mode != SSO_MODE_POS |=> !in_position) // R7
        else $error("in-position outside position mode");
    chk_dbi_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && dyn_brake_req |=> !dyn_brake_interlock) // R9
        else $error("dynamic brake interlock on while braking");
    chk_ready_servo: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ready |-> $past(s_reg.servo_on)) // R12
        else $error("ready without servo-on");
    chk_sa_servo_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !servo_eff |=> !speed_reached) // R13
        else $error("speed reached during servo-off");
    chk_sa_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        speed_reached |-> $past(ctrl_mode) == SSO_MODE_VEL) // R16
        else $error("speed reached outside velocity mode");
    chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    cov_servo_ready: cover property (@(posedge sys_clk) disable iff (!rst_b)
        ready && speed_reached);
    cov_malf_on: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(malfunction_out));
    cov_dip: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(s_reg.dip_latch));
    cov_irq: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(irq));
endmodule // sso_status_out

// ### sso_map.svh
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH
// Notes on behaviour
// [R1] Three assignable pins; defaults brake interlock, in-position, malfunction.
// [R2] Brake interlock goes off on servo-off or any alarm.
// [R3] Operator sets brake delay parameter when brake interlock is used.
// [R4] Malfunction goes off when protection shuts off the base drive.
// [R5] Without alarm, malfunction turns on 2.5 s to 3.5 s after power-up.
// [R6] In-position on while droop count lies within the configured range.
// [R7] In-position is only meaningful in position control mode.
// [R8] Operator assigns dynamic brake interlock to a pin to use it.
// [R9] Dynamic brake interlock goes off whenever the dynamic brake must act.
// [R10] External dynamic brake on 11 kW or more needs the interlock output.
// [R11] Assigned dynamic brake interlock forces servo-off on power dip.
// [R12] Ready turns on once servo-on is enabled and amplifier is ready.
// [R13] Speed-reached held off during servo-off.
// [R14] Speed-reached on within command plus or minus 5 percent plus 20.
// [R15] Command of 20 r/min or less keeps speed-reached on.
// [R16] Speed-reached only available in velocity mode.
// [R17] All outputs update synchronously once per control cycle.
`define SSO_ADDR_CTRL 4'h0
`define SSO_ADDR_INPR 4'h1
`define SSO_ADDR_ASSIGN 4'h2
`define SSO_ADDR_STATUS 4'h3
`define SSO_ADDR_IRQ_STAT 4'h4
`define SSO_ADDR_IRQ_EN 4'h5
`define SSO_ADDR_IRQ_CLR 4'h6
`define SSO_ADDR_BRK_DLY 4'h7
`define SSO_CTRL_SERVO_ON 0
`define SSO_INPR_RESET 32'h0000_0064
`define SSO_BRK_DLY_RESET 32'h0000_0000
`define SSO_ASSIGN_RESET 12'h210
`define SSO_SA_PCT_NUM 32'd5
`define SSO_SA_PCT_DEN 32'd100
`define SSO_SA_OFFSET 32'd20
`define SSO_ALM_MIN_MS 32'd2500
`define SSO_ALM_MAX_MS 32'd3500
`define SSO_CLK_KHZ 32'd200000
`define SSO_ALM_MIN_CYC (`SSO_ALM_MIN_MS * `SSO_CLK_KHZ)
`define SSO_ALM_MAX_CYC (`SSO_ALM_MAX_MS * `SSO_CLK_KHZ)
`endif

// ### sso_pkg.sv
package sso_pkg;
    // Status source codes for the assignable pins
    typedef enum logic [3:0] {
        SSO_SRC_BRAKE = 4'h0,
        SSO_SRC_INPOS = 4'h1,
        SSO_SRC_MALF = 4'h2,
        SSO_SRC_DYNBRK = 4'h3,
        SSO_SRC_READY = 4'h4,
        SSO_SRC_SPEED = 4'h5,
        SSO_SRC_OFF = 4'h6
    } sso_src_t;
    typedef enum logic [1:0] {
        SSO_MODE_POS = 2'h0,
        SSO_MODE_VEL = 2'h1,
        SSO_MODE_TRQ = 2'h2
    } sso_mode_t;
    typedef enum logic [1:0] {
        SSO_BUS_IDLE = 2'h0,
        SSO_BUS_ANSWER = 2'h1
    } sso_bus_st_t;
endpackage

// ### sso_pin_mux.sv
`timescale 1ns/1ps
// Picks one status source per assignable pin
module sso_pin_mux import sso_pkg::*; #(
    parameter int PINS = 3
) (
    // Selects
    input wire logic [4*PINS-1:0] sel,
    // Status vector indexed by source code
    input wire logic [7:0] status,
    // Pin levels
    output logic [PINS-1:0] pin
);
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            // Codes past the vector read as off
            assign pin[i] = sel[4*i+3] ? 1'b0 : status[sel[4*i+:3]]; // R1
        end
    endgenerate
endmodule // sso_pin_mux

// ### sso_relay_model.sv
`timescale 1ns/1ps
// External brake and dynamic brake relays fed by the status outputs
module sso_relay_model #(
    parameter int DLY = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Coil drives from the amplifier
    input wire logic brake_interlock,
    input wire logic db_coil,
    // Relay states
    output logic brake_held,
    output logic db_active
);
    int cnt;
    // Brake lets go only after its delay, engages at once
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b || !brake_interlock) begin
            cnt <= 0;
            brake_held <= 1'b1;
        end else if (cnt < DLY) begin
            cnt <= cnt + 1;
        end else begin
            brake_held <= 1'b0;
        end
    end
    // Contact closes when the coil drops; fitted on large frames
    assign db_active = !db_coil;
endmodule // sso_relay_model

// ### servo_status_outputs_tb.sv
`timescale 1ns/1ps
`include "sso_map.svh"
module servo_status_outputs_tb;
    import sso_pkg::*;
    logic sys_clk, rst_b, rd, wr, alarm, shut, rdy_in, dbr, dip;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, expq[$];
    logic [1:0] mode;
    logic signed [31:0] droop, spd, cmd;
    logic [2:0] pins;
    logic wreq, brk, malf, inp, dbi, rdy, sa, son, irq, held, dba;
    int n_fail, samples_checked, t, c, tol;
    sso_status_out #(.ALM_MIN_CYC(32'd100), .ALM_MAX_CYC(32'd150)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .alarm(alarm), .base_shutoff(shut),
        .amp_ready(rdy_in), .dyn_brake_req(dbr), .power_dip(dip),
        .ctrl_mode(mode), .droop_count(droop), .motor_speed(spd),
        .cmd_speed(cmd), .out_pin(pins), .brake_interlock(brk),
        .malfunction_out(malf), .in_position(inp),
        .dyn_brake_interlock(dbi), .ready(rdy), .speed_reached(sa),
        .servo_on_eff(son), .irq(irq));
    sso_relay_model relay_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .brake_interlock(brk), .db_coil(dbi), .brake_held(held),
        .db_active(dba));
    // Free running clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus cycle; request held until waitrequest seen low
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(negedge sys_clk);
        while (wreq !== 1'b0) @(negedge sys_clk);
        @(posedge sys_clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdx(logic [3:0] a, logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Status path is two registers deep to the pins
    task automatic st();
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read data taken at the answering edge, oldest note first
    always @(negedge sys_clk) begin
        if (rd && wreq === 1'b0) begin
            if (expq.size() == 0) chk("spare_read", 1, 0);
            else chk("readdata", rdata, expq.pop_front());
        end
    end
    // Hang guard
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial begin
        t = $urandom(30150);
        {rst_b, rd, wr, alarm, shut, rdy_in, dbr, dip} = '0;
        addr = 4'h0;
        wdata = '0;
        mode = SSO_MODE_POS;
        droop = 0;
        spd = 0;
        cmd = 0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t = 0;
        while (malf !== 1'b1 && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        chk("malf_delay", t >= 98 && t <= 152, 1);
        st();
        chk("pin_c", pins[2], 1);
        rdx(`SSO_ADDR_INPR, `SSO_INPR_RESET);
        rdx(4'hF, 32'h0);
        bus(1'b1, `SSO_ADDR_BRK_DLY, 32'h0000_0004);
        rdx(`SSO_ADDR_BRK_DLY, 32'h0000_0004);
        rdy_in <= 1'b1;
        bus(1'b1, `SSO_ADDR_CTRL, 32'h1);
        st();
        chk("ready", rdy, 1);
        chk("pin_a", pins[0], 1);
        chk("irq_masked", irq, 0);
        bus(1'b1, `SSO_ADDR_IRQ_EN, 32'h10);
        st();
        chk("irq_on", irq, 1);
        bus(1'b1, `SSO_ADDR_IRQ_CLR, 32'h10);
        st();
        chk("irq_clr", irq, 0);
        chk("brake_free", held, 0);
        // Random commands, just inside and outside the band
        mode <= SSO_MODE_VEL;
        for (int i = 0; i < 4; i++) begin
            c = 200 + $urandom_range(1800);
            tol = c * 5 / 100 + 20;
            cmd <= c;
            spd <= c + tol - 1;
            st();
            chk("sa_in", sa, 1);
            spd <= c - tol - 1;
            st();
            chk("sa_out", sa, 0);
        end
        cmd <= 10;
        st();
        chk("sa_slow", sa, 1);
        bus(1'b1, `SSO_ADDR_CTRL, 32'h0);
        st();
        chk("sa_off", sa, 0);
        chk("brk_off", brk, 0);
        bus(1'b1, `SSO_ADDR_CTRL, 32'h1);
        mode <= SSO_MODE_POS;
        st();
        chk("sa_pos", sa, 0);
        c = 1 + $urandom_range(999);
        bus(1'b1, `SSO_ADDR_INPR, c);
        droop <= c / 2;
        st();
        chk("inp_in", inp, 1);
        droop <= c + 1;
        st();
        chk("inp_out", inp, 0);
        droop <= 0;
        mode <= SSO_MODE_VEL;
        st();
        chk("inp_vel", inp, 0);
        mode <= SSO_MODE_POS;
        dip <= 1'b1;
        st();
        chk("dip_unassigned", son, 1);
        dip <= 1'b0;
        // Every source code on pin A, others off
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, `SSO_ADDR_ASSIGN, 32'h660 | i);
            st();
            chk("pin_a_code", pins[0], i < 5);
        end
        rdx(`SSO_ADDR_ASSIGN, 32'h667);
        bus(1'b1, `SSO_ADDR_ASSIGN, 32'h663);
        dbr <= 1'b1;
        st();
        chk("dbi", dbi, 0);
        chk("db_pin", pins[0], 0);
        chk("db_relay", dba, 1);
        dbr <= 1'b0;
        dip <= 1'b1;
        st();
        chk("dip_drop", son, 0);
        dip <= 1'b0;
        alarm <= 1'b1;
        st();
        chk("brk_alarm", brk, 0);
        chk("brake_held", held, 1);
        shut <= 1'b1;
        st();
        chk("malf_shut", malf, 0);
        stop_test();
    end
endmodule // servo_status_outputs_tb
